// ==== pchu_config_upper.sv ====
`timescale 1ns/1ps
`default_nettype none
module pchu_config_upper #(
	parameter logic [15:0] DEV_IDENT  = pchu_pkg::DEV_IDENT_DEF,
	parameter logic [15:0] VEND_IDENT = pchu_pkg::VEND_IDENT_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        eeLoad,
	input  wire logic [15:0] eeSubsysIdent,
	input  wire logic [15:0] eeSubsysVendorIdent,
	input  wire logic [7:0]  eeMaxLatency,
	input  wire logic [7:0]  eeMinGrant,
	input  wire logic [31:0] memAddr,
	input  wire logic        memReq,
	output logic             romHit,
	output logic [17:0]      romOffset,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	logic [15:0] subsystemIdent;
	logic [15:0] subsystemVendorIdent;
	logic [7:0]  maxLatencyHint;
	logic [7:0]  minGrantHint;
	logic [14:0] romWindowBase;
	logic        romWindowEnable;
	logic        memorySpaceEnable;
	logic [7:0]  interruptLineNumber;
	logic [7:0]  driverScratchByte;

	// write side: address and data latched independently
	logic        awHeld;
	logic        wHeld;
	logic [7:0]  wAddr;
	logic [31:0] wData;
	logic [3:0]  wStrb;

	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake  = s_axi_wvalid & s_axi_wready;
	wire doWrite = awHeld & wHeld & ~s_axi_bvalid;

	wire wrRomBase  = doWrite & (wAddr == pchu_pkg::OFS_ROMBASE);
	wire wrIntHint  = doWrite & (wAddr == pchu_pkg::OFS_INTHINT);
	wire wrScratch  = doWrite & (wAddr == pchu_pkg::OFS_SCRATCH);
	wire wrControl  = doWrite & (wAddr == pchu_pkg::OFS_CONTROL);
	wire wrMapped   = wrRomBase | wrIntHint | wrScratch | wrControl |
		(wAddr == pchu_pkg::OFS_SUBSYS) | (wAddr == pchu_pkg::OFS_CAPPTR) |
		(wAddr == pchu_pkg::OFS_SIGNATURE);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			wAddr         <= 8'h00;
			wData         <= 32'h0000_0000;
			wStrb         <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pchu_pkg::RESP_OKAY;
		end else begin
			if (awTake) begin
				awHeld        <= 1'b1;
				wAddr         <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (wTake) begin
				wHeld        <= 1'b1;
				wData        <= s_axi_wdata;
				wStrb        <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrMapped ? pchu_pkg::RESP_OKAY
					: pchu_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				awHeld        <= 1'b0;
				wHeld         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// eeprom-loaded fields; reload stands in for the reset value
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			subsystemIdent       <= 16'h0000;
			subsystemVendorIdent <= 16'h0000;
			maxLatencyHint       <= 8'h00;
			minGrantHint         <= 8'h00;
		end else if (eeLoad) begin
			subsystemIdent       <= eeSubsysIdent;
			subsystemVendorIdent <= eeSubsysVendorIdent;
			maxLatencyHint       <= eeMaxLatency;
			minGrantHint         <= eeMinGrant;
		end
	end

	// writable fields; byte lanes honoured
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			romWindowBase       <= 15'h0000;
			romWindowEnable     <= 1'b0;
			memorySpaceEnable   <= 1'b0;
			interruptLineNumber <= 8'h00;
		end else begin
			if (wrRomBase & wStrb[2])
				romWindowBase[6:0] <= wData[23:17];
			if (wrRomBase & wStrb[3])
				romWindowBase[14:7] <= wData[31:24];
			if (wrRomBase & wStrb[0])
				romWindowEnable <= wData[pchu_pkg::ROM_EN_BIT];
			if (wrControl & wStrb[0])
				memorySpaceEnable <= wData[pchu_pkg::MEM_EN_BIT];
			if (wrIntHint & wStrb[0])
				interruptLineNumber <= wData[7:0];
		end
	end

	// scratch clears on the controller's soft reset, srst, like the other writable fields
	always_ff @(posedge clk_sys) begin
		if (srst)
			driverScratchByte <= 8'h00;
		else if (wrScratch & wStrb[1])
			driverScratchByte <= wData[15:8];
	end

	// read side
	wire [7:0] rAddr = {s_axi_araddr[7:2], 2'b00};
	wire [31:0] wordSubsys = {subsystemIdent, subsystemVendorIdent};
	wire [31:0] wordRomBase = {romWindowBase, 16'h0000,
		romWindowEnable};
	wire [31:0] wordCapPtr = {24'h000000,
		pchu_pkg::CAP_PTR_VALUE};
	wire [31:0] wordIntHint = {maxLatencyHint, minGrantHint,
		pchu_pkg::INT_PIN_VALUE, interruptLineNumber};
	wire [31:0] wordScratch = {16'h0000, driverScratchByte,
		8'h00};
	wire [31:0] wordControl = {30'h00000000, memorySpaceEnable,
		1'b0};
	wire [31:0] wordSignature = {DEV_IDENT, VEND_IDENT};

	wire hitSubsys  = rAddr == pchu_pkg::OFS_SUBSYS;
	wire hitRomBase = rAddr == pchu_pkg::OFS_ROMBASE;
	wire hitCapPtr  = rAddr == pchu_pkg::OFS_CAPPTR;
	wire hitIntHint = rAddr == pchu_pkg::OFS_INTHINT;
	wire hitScratch = rAddr == pchu_pkg::OFS_SCRATCH;
	wire hitControl = rAddr == pchu_pkg::OFS_CONTROL;
	wire hitSig     = rAddr == pchu_pkg::OFS_SIGNATURE;
	wire rdMapped = hitSubsys | hitRomBase | hitCapPtr | hitIntHint |
		hitScratch | hitControl | hitSig;
	wire [31:0] readWord =
		({32{hitSubsys}}  & wordSubsys)  |
		({32{hitRomBase}} & wordRomBase) |
		({32{hitCapPtr}}  & wordCapPtr)  |
		({32{hitIntHint}} & wordIntHint) |
		({32{hitScratch}} & wordScratch) |
		({32{hitControl}} & wordControl) |
		({32{hitSig}}     & wordSignature);
	wire arTake = s_axi_arvalid & s_axi_arready;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= pchu_pkg::ZERO_WORD;
			s_axi_rresp   <= pchu_pkg::RESP_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= readWord; // unmapped reads zero
			s_axi_rresp   <= rdMapped ? pchu_pkg::RESP_OKAY
				: pchu_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	pchu_rom_window u_rom (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.memAddr   (memAddr),
		.memReq    (memReq),
		.romBase   (romWindowBase),
		.romEnable (romWindowEnable),
		.memEnable (memorySpaceEnable),
		.romHit    (romHit),
		.romOffset (romOffset)
	);
endmodule
`default_nettype wire

// ==== pchu_pkg.sv ====
// Operation
// - subsystem identity reads back the eeprom-loaded subsystem id (31:16) and vendor id (15:0), read-only.
// - rom window base is writable only in bits 31:17, lower address bits read zero, giving a 128 KB window.
// - rom window accesses are answered only when rom window enable and memory space enable are both one.
// - writing all ones to the rom window base reads back fffe0001; software programs it before rom use.
// - capability list pointer is read-only and returns c0, upper bits zero.
// - max latency hint (31:24) is read-only, in 250 ns units, loaded from eeprom after reset.
// - min grant hint (23:16) is read-only, in 250 ns units, loaded from eeprom after reset.
// - interrupt pin code (15:8) always reads 01.
// - interrupt line number (7:0) is a plain read-write store with no hardware effect.
// - driver scratch byte (15:8) is read-write and is cleared by srst like the other writable fields; other bits reserved.
// - signature is hard-wired read-only, device ident high and vendor ident low.
// - memory space enable is read-write, one permits and zero blocks memory responses.
`default_nettype none
package pchu_pkg;
	localparam logic [7:0] OFS_SUBSYS    = 8'h2c;
	localparam logic [7:0] OFS_ROMBASE   = 8'h30;
	localparam logic [7:0] OFS_CAPPTR    = 8'h34;
	localparam logic [7:0] OFS_INTHINT   = 8'h3c;
	localparam logic [7:0] OFS_SCRATCH   = 8'h40;
	localparam logic [7:0] OFS_CONTROL   = 8'h44;
	localparam logic [7:0] OFS_SIGNATURE = 8'h80;
	localparam int ROM_BASE_LSB = 17;
	localparam int ROM_EN_BIT   = 0;
	localparam int MEM_EN_BIT   = 1;
	localparam int SCRATCH_LSB  = 8;
	localparam logic [7:0]  CAP_PTR_VALUE  = 8'hc0;
	localparam logic [7:0]  INT_PIN_VALUE  = 8'h01;
	localparam logic [15:0] DEV_IDENT_DEF  = 16'h5a01; // arbitrary value
	localparam logic [15:0] VEND_IDENT_DEF = 16'h5a02; // arbitrary value
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam int HINT_UNIT_NS = 250;
	localparam int CLK_NS       = 20;
	localparam int HINT_UNIT_CYC = (HINT_UNIT_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ==== pchu_rom_window.sv ====
`timescale 1ns/1ps
`default_nettype none
module pchu_rom_window (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [31:0] memAddr,
	input  wire logic        memReq,
	input  wire logic [14:0] romBase,
	input  wire logic        romEnable,
	input  wire logic        memEnable,
	output logic             romHit,
	output logic [17:0]      romOffset
);
	// only the upper address bits compare, so a 128 KB window
	wire addrMatch = memAddr[31:pchu_pkg::ROM_BASE_LSB] == romBase;
	wire allowed   = romEnable & memEnable;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			romHit    <= 1'b0;
			romOffset <= 18'h00000;
		end else begin
			romHit    <= memReq & addrMatch & allowed;
			romOffset <= memAddr[17:0];
		end
	end
endmodule
`default_nettype wire

// ==== pchu_config_upper_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pchu_config_upper_asserts #(
	parameter logic [15:0] DEV_IDENT  = pchu_pkg::DEV_IDENT_DEF,
	parameter logic [15:0] VEND_IDENT = pchu_pkg::VEND_IDENT_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic [31:0] memAddr,
	input  wire logic        memReq,
	input  wire logic        romHit,
	input  wire logic [17:0] romOffset,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready
);
	wire logic       rt = s_axi_arvalid && s_axi_arready;
	wire logic [7:0] ra = s_axi_araddr;
	wire logic       ok = ra inside {8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h44, 8'h80};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_cap; rt && ra == 8'h34 |=> s_axi_rdata == 32'h0000_00c0; endproperty
	a_cap: assert property (p_cap) else $error("bad pointer");
	property p_sig; rt && ra == 8'h80 |=> s_axi_rdata == {DEV_IDENT, VEND_IDENT}; endproperty
	a_sig: assert property (p_sig) else $error("bad signature");
	property p_pin; rt && ra == 8'h3c |=> s_axi_rdata[15:8] == 8'h01; endproperty
	a_pin: assert property (p_pin) else $error("bad pin code");
	property p_scr; rt && ra == 8'h40 |=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[7:0] == 8'h0; endproperty
	a_scr: assert property (p_scr) else $error("scratch reserved set");
	property p_rom; rt && ra == 8'h30 |=> s_axi_rdata[16:1] == 16'h0; endproperty
	a_rom: assert property (p_rom) else $error("rom base low bits");
	property p_unm; rt && !ok |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_off; memReq |=> romOffset == $past(memAddr[17:0]); endproperty
	a_off: assert property (p_off) else $error("bad rom offset");
	property p_hit; romHit |-> $past(memReq); endproperty
	a_hit: assert property (p_hit) else $error("hit without request");
	c_hit: cover property (romHit);
	c_unm: cover property (rt && !ok);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pchu_config_upper pchu_config_upper_asserts #(.DEV_IDENT(DEV_IDENT), .VEND_IDENT(VEND_IDENT)) chk_u (.*);
`default_nettype wire

// ==== pchu_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pchu_host_model (
	input  wire logic        clk_sys,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	output var logic         s_axi_awvalid = 1'b0,
	output var logic [7:0]   s_axi_awaddr = 8'h0,
	output var logic         s_axi_wvalid = 1'b0,
	output var logic [31:0]  s_axi_wdata = 32'h0,
	output var logic [3:0]   s_axi_wstrb = 4'hf,
	output var logic         s_axi_bready = 1'b0,
	output var logic         s_axi_arvalid = 1'b0,
	output var logic [7:0]   s_axi_araddr = 8'h0,
	output var logic         s_axi_rready = 1'b0,
	output var logic         stuck = 1'b0
);
	// each channel released only at its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [2:0] left;
		left = 3'b111;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		for (int n = 0; n < 64 && left != 3'b0; n++) begin
			s_axi_awvalid <= left[2];
			s_axi_wvalid <= left[1];
			s_axi_bready <= left[0];
			@(posedge clk_sys);
			left = left & ~{s_axi_awready, s_axi_wready, s_axi_bvalid};
		end
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		stuck <= stuck | (left != 3'b0);
	endtask
	task automatic rd(input logic [7:0] a);
		logic [1:0] left;
		left = 2'b11;
		s_axi_araddr <= a;
		for (int n = 0; n < 64 && left != 2'b0; n++) begin
			s_axi_arvalid <= left[1];
			s_axi_rready <= left[0];
			@(posedge clk_sys);
			left = left & ~{s_axi_arready, s_axi_rvalid};
		end
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		stuck <= stuck | (left != 2'b0);
	endtask
endmodule
`default_nettype wire

// ==== pchu_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_sys = 1'b0, srst = 1'b1, eeLoad = 1'b0, memReq = 1'b0;
	logic [15:0] eeSubsysIdent = 16'h0, eeSubsysVendorIdent = 16'h0;
	logic [7:0]  eeMaxLatency = 8'h0, eeMinGrant = 8'h0, s_axi_awaddr, s_axi_araddr;
	logic [31:0] memAddr = 32'h0, s_axi_wdata, s_axi_rdata, aft[7];
	logic [17:0] romOffset, off;
	logic [14:0] base;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ctl;
	logic        romHit, stuck, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [33:0] expq[$];
	int          failures = 0, n_checks = 0;
	localparam logic [7:0] OFS[7] = '{8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h44, 8'h80};
	localparam logic [31:0] SIG = {pchu_pkg::DEV_IDENT_DEF, pchu_pkg::VEND_IDENT_DEF};
	pchu_config_upper dut_u (.*);
	pchu_host_model host_u (.*);
	always #10 clk_sys = ~clk_sys;
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expq.push_back(e);
		host_u.rd(a);
		// one idle edge so valid never drops and rises in one step
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		expq.push_back({r, 32'h0});
		host_u.wr(a, d);
		@(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (stuck === 1'b1) begin
			failures++;
			report_and_stop;
		end
		if (s_axi_rvalid === 1'b1 && s_axi_rready)
			check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
		else if (s_axi_bvalid === 1'b1 && s_axi_bready)
			check({s_axi_bresp, 32'h0}, expq.pop_front());
	end
	initial begin
		void'($urandom(7621));
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		aft = '{32'h0, 32'h0, 32'hc0, 32'h100, 32'h0, 32'h0, SIG};
		for (int i = 0; i < 7; i++)
			rd(OFS[i], {2'h0, aft[i]});
		{eeSubsysIdent, eeSubsysVendorIdent} <= $urandom;
		{eeMaxLatency, eeMinGrant} <= $urandom;
		eeLoad <= 1'b1;
		@(posedge clk_sys);
		eeLoad <= 1'b0;
		@(posedge clk_sys);
		// all-ones into every register shows writable bits only
		aft = '{{eeSubsysIdent, eeSubsysVendorIdent}, 32'hfffe0001, 32'hc0,
			{eeMaxLatency, eeMinGrant, 16'h01ff}, 32'hff00, 32'h2, SIG};
		for (int i = 0; i < 7; i++) begin
			wr(OFS[i], 32'hffffffff, 2'h0);
			rd(OFS[i], {2'h0, aft[i]});
		end
		wr(8'h48, 32'hffffffff, 2'h2);
		rd(8'h48, {2'h2, 32'h0});
		base = 15'($urandom);
		for (int i = 0; i < 5; i++) begin
			ctl = (i == 4) ? 2'b11 : 2'(i);
			off = {i == 4 ? ~base[0] : base[0], 17'($urandom)};
			wr(8'h44, {30'h0, ctl[1], 1'b0}, 2'h0);
			wr(8'h30, {base, 16'h0, ctl[0]}, 2'h0);
			memAddr <= {i == 4 ? ~base[14:1] : base[14:1], off};
			memReq <= 1'b1;
			@(posedge clk_sys);
			memReq <= 1'b0;
			@(negedge clk_sys);
			check({15'h0, romHit, romOffset}, {15'h0, i == 3, off});
		end
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		rd(8'h3c, {2'h0, 32'h100});
		rd(8'h40, {2'h0, 32'h0});
		repeat (2) @(posedge clk_sys);
		report_and_stop;
	end
endmodule
`default_nettype wire
